// ---- acr_pkg.sv ----
// Package with offsets, field layouts and encodings of the converter block
`default_nettype none
package acr_pkg;
    localparam logic [7:0] IO_SEL_OFS = 8'h07;
    localparam logic [7:0] IO_RES_LO_OFS = 8'h04;
    localparam logic [7:0] IO_RES_HI_OFS = 8'h05;
    localparam logic [7:0] DATA_SPACE_BASE = 8'h20;
    localparam logic [7:0] IO_MAX_OFS = 8'h3f;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int ALIGN_BIT = 5;
    localparam int CHAN_MSB = 4;
    localparam int CHAN_LSB = 0;
    localparam int RES_W = 10;
    localparam logic [RES_W-1:0] RES_RESET = 10'h000;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [4:0] DIFF_FIRST = 5'h08;
    localparam logic [4:0] DIFF_LAST = 5'h1d;
    typedef enum logic [1:0] {
        ACR_REF_EXT = 2'h0,
        ACR_REF_SUPPLY = 2'h1,
        ACR_REF_RSVD = 2'h2,
        ACR_REF_INT = 2'h3
    } acr_ref_t;
endpackage : acr_pkg
`default_nettype wire

// ---- acr_format.sv ----
// Result formatter: places a 10-bit code into two bytes by alignment
`timescale 1ns/1ps
`default_nettype none
module acr_format (
    input wire logic [9:0] code,        // Stored conversion code
    input wire logic left_align,        // One selects left alignment
    output logic [7:0] low_byte,        // Formatted low byte
    output logic [7:0] high_byte        // Formatted high byte
);
    always_comb begin
        if (left_align) begin
            high_byte = code[9:2];
            low_byte = {code[1:0], 6'h00};
        end else begin
            high_byte = {6'h00, code[9:8]};
            low_byte = code[7:0];
        end
    end
endmodule : acr_format
`default_nettype wire

// ---- acr_result_select.sv ----
// Result formatting and buffered input selection of a 10-bit converter
// Function
// - Result bytes readable once the done flag is set for that conversion.
// - Single-ended result is an unsigned 10-bit code, 0x000 to 0x3ff.
// - Differential result is a signed two's complement code, 0x200 to 0x1ff.
// - Differential sign sits in result bit 9, inside the high byte.
// - Selection register at I/O offset 0x07, data space offset plus 0x20.
// - Selection register resets to zero, every bit read and write.
// - Bits 7:6 reference, bit 5 left align, bits 4:0 channel and gain.
// - Reference writes during a conversion apply only after it completes.
// - Reference codes: 00 external pin, 01 supply, 10 reserved, 11 internal.
// - Left align bit one gives left aligned bytes, zero right aligned.
// - Channel and gain writes during a conversion apply after it completes.
// - Left align changes re-present result bytes at once.
// - Done flag sets when a conversion completes and bytes are updated.
`timescale 1ns/1ps
`default_nettype none
module acr_result_select (
    input wire logic clk_sys,            // System clock, 100 MHz
    input wire logic rst_n,              // Asynchronous reset, active low
    input wire logic [7:0] io_addr,      // Register address
    input wire logic io_data_space,      // One: address is data space form
    input wire logic io_we,              // Write strobe
    input wire logic io_re,              // Read strobe
    input wire logic [7:0] io_wdata,     // Write data
    output logic [7:0] io_rdata,         // Read data, registered
    input wire logic conv_start,         // Pulse: analog side starts sampling
    input wire logic conv_complete,      // Pulse: analog side finished
    input wire logic [9:0] conv_code,    // Raw code with conv_complete
    input wire logic done_flag_clear,    // Pulse: clear done flag
    output logic conversion_done_flag,   // Sticky completion flag
    output logic conv_busy,              // Conversion in progress
    output logic [1:0] reference_select, // Active reference selection
    output logic [4:0] channel_gain_select, // Active channel and gain
    output logic external_reference_pin, // External pin used as reference
    output logic analog_supply_reference, // Supply used as reference
    output logic internal_ref_enable,    // Internal reference powered
    output logic result_is_differential  // Active channel is differential
);
    logic [7:0] sel_q, sel_d;
    logic [1:0] ref_q, ref_d;
    logic [4:0] chan_q, chan_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [9:0] res_q, res_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] ofs;
    logic ofs_ok;
    logic hit_sel, hit_lo, hit_hi;
    logic sel_write;
    logic [7:0] res_lo, res_hi;
    logic left_align_result;

    assign left_align_result = sel_q[acr_pkg::ALIGN_BIT];

    // Field layout must tile the eight register bits without gaps
    if (acr_pkg::REF_MSB != 7 || acr_pkg::CHAN_LSB != 0 ||
        acr_pkg::REF_LSB != acr_pkg::ALIGN_BIT + 1 ||
        acr_pkg::ALIGN_BIT != acr_pkg::CHAN_MSB + 1) begin : g_layout_bad
        $error("selection field layout does not fill eight bits");
    end
    if (acr_pkg::RES_W != 10) begin : g_width_bad
        $error("result formatter serves a 10-bit code only");
    end

    // Both addressing forms land on the same offset
    always_comb begin
        ofs_ok = 1'b1;
        ofs = io_addr;
        if (io_data_space) begin
            ofs = io_addr - acr_pkg::DATA_SPACE_BASE;
            ofs_ok = (io_addr >= acr_pkg::DATA_SPACE_BASE) &&
                     (ofs <= acr_pkg::IO_MAX_OFS);
        end else if (io_addr > acr_pkg::IO_MAX_OFS) begin
            ofs_ok = 1'b0;
        end
        hit_sel = ofs_ok && (ofs == acr_pkg::IO_SEL_OFS);
        hit_lo = ofs_ok && (ofs == acr_pkg::IO_RES_LO_OFS);
        hit_hi = ofs_ok && (ofs == acr_pkg::IO_RES_HI_OFS);
        sel_write = io_we && hit_sel;
    end

    acr_format u_fmt (
        .code(res_q),
        .left_align(left_align_result),
        .low_byte(res_lo),
        .high_byte(res_hi)
    );

    // Software copy of the selection register, writable at any time
    always_comb begin
        sel_d = sel_q;
        if (sel_write) begin
            sel_d = io_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= acr_pkg::SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    // Busy spans start to completion; completion wins a tie with start
    always_comb begin
        busy_d = busy_q;
        if (conv_start) begin
            busy_d = 1'b1;
        end
        if (conv_complete) begin
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= acr_pkg::FLAG_RESET;
        end else begin
            busy_q <= busy_d;
        end
    end

    // A clear in the completing cycle loses, so no completion is missed
    always_comb begin
        done_d = done_q;
        if (done_flag_clear) begin
            done_d = 1'b0;
        end
        if (conv_complete) begin
            done_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= acr_pkg::FLAG_RESET;
        end else begin
            done_q <= done_d;
        end
    end

    // Active copy follows the register except while a conversion runs;
    // the completing cycle already takes the pending value
    always_comb begin
        ref_d = ref_q;
        chan_d = chan_q;
        if (!busy_q || conv_complete) begin
            ref_d = sel_d[acr_pkg::REF_MSB:acr_pkg::REF_LSB];
            chan_d = sel_d[acr_pkg::CHAN_MSB:acr_pkg::CHAN_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= acr_pkg::SEL_RESET[acr_pkg::REF_MSB:acr_pkg::REF_LSB];
            chan_q <= acr_pkg::SEL_RESET[acr_pkg::CHAN_MSB:acr_pkg::CHAN_LSB];
        end else begin
            ref_q <= ref_d;
            chan_q <= chan_d;
        end
    end

    // Result store keeps the last completed code until the next one
    always_comb begin
        res_d = res_q;
        if (conv_complete) begin
            res_d = conv_code;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= acr_pkg::RES_RESET;
        end else begin
            res_q <= res_d;
        end
    end

    // Read data is captured at the strobe edge and held until the next
    always_comb begin
        rdata_d = rdata_q;
        if (io_re) begin
            rdata_d = acr_pkg::UNMAPPED_RDATA;
            if (hit_sel) begin
                rdata_d = sel_q;
            end else if (hit_lo) begin
                rdata_d = res_lo;
            end else if (hit_hi) begin
                rdata_d = res_hi;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= acr_pkg::RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Reference source decode
    always_comb begin
        external_reference_pin = 1'b0;
        analog_supply_reference = 1'b0;
        internal_ref_enable = 1'b0;
        case (acr_pkg::acr_ref_t'(ref_q))
            acr_pkg::ACR_REF_EXT: external_reference_pin = 1'b1;
            acr_pkg::ACR_REF_SUPPLY: analog_supply_reference = 1'b1;
            acr_pkg::ACR_REF_INT: internal_ref_enable = 1'b1;
            default: ;
        endcase
    end

    assign result_is_differential = (chan_q >= acr_pkg::DIFF_FIRST) &&
                                    (chan_q <= acr_pkg::DIFF_LAST);
    assign io_rdata = rdata_q;
    assign conversion_done_flag = done_q;
    assign conv_busy = busy_q;
    assign reference_select = ref_q;
    assign channel_gain_select = chan_q;
endmodule : acr_result_select
`default_nettype wire

// ---- acr_result_select_sva.sv ----
// Checker of the converter result and selection block
`timescale 1ns/1ps
`default_nettype none
module acr_result_select_sva (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input wire logic conv_start, // Start
    input wire logic conv_complete, // End
    input wire logic done_flag_clear, // Clear
    input wire logic conversion_done_flag, // Flag
    input wire logic conv_busy, // Busy
    input wire logic [1:0] reference_select, // Ref
    input wire logic [4:0] channel_gain_select, // Chan
    input wire logic external_reference_pin, // Ext
    input wire logic analog_supply_reference, // Supply
    input wire logic internal_ref_enable, // Int
    input wire logic result_is_differential // Diff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    flag_set_a: assert property (
        conv_complete |=> conversion_done_flag)
        else $error("done flag not set");
    flag_hold_a: assert property (
        conversion_done_flag && !done_flag_clear |=> conversion_done_flag)
        else $error("done flag lost");
    flag_clear_a: assert property (
        done_flag_clear && !conv_complete |=> !conversion_done_flag)
        else $error("done flag not cleared");
    busy_set_a: assert property (
        conv_start && !conv_complete |=> conv_busy)
        else $error("busy not set");
    busy_clr_a: assert property (
        conv_complete |=> !conv_busy)
        else $error("busy not cleared");
    ref_lock_a: assert property (
        conv_busy && !conv_complete |=> $stable(reference_select))
        else $error("reference moved");
    chan_lock_a: assert property (
        conv_busy && !conv_complete |=> $stable(channel_gain_select))
        else $error("channel moved");
    ref_decode_a: assert property ({external_reference_pin,
        analog_supply_reference, internal_ref_enable} == {reference_select
        == 2'h0, reference_select == 2'h1, reference_select == 2'h3})
        else $error("reference decode wrong");
    diff_decode_a: assert property (result_is_differential ==
        (channel_gain_select inside {[5'h08:5'h1d]}))
        else $error("differential decode wrong");
endmodule : acr_result_select_sva
bind acr_result_select acr_result_select_sva u_acr_result_select_sva (.*);
`default_nettype wire

// ---- acr_analog_model.sv ----
// Analog side model: start and completion pulses with the raw code
`timescale 1ns/1ps
`default_nettype none
module acr_analog_model (
    input wire logic clk_sys, // Clock
    output logic conv_start, // Start pulse
    output logic conv_complete, // End pulse
    output logic [9:0] conv_code // Code, junk outside the end pulse
);
    // No shared digital pin is driven here
    initial begin
        conv_start = 1'b0;
        conv_complete = 1'b0;
        conv_code = 10'h155;
    end
    task automatic begin_conv;
        conv_start = 1'b1;
        @(negedge clk_sys);
        conv_start = 1'b0;
    endtask : begin_conv
    task automatic end_conv(input logic [9:0] c);
        conv_code = c;
        conv_complete = 1'b1;
        @(negedge clk_sys);
        conv_complete = 1'b0;
        conv_code = ~c;
    endtask : end_conv
endmodule : acr_analog_model
`default_nettype wire

// ---- acr_result_select_tb_top.sv ----
// Self-checking bench of the converter result and selection block
`timescale 1ns/1ps
`default_nettype none
module acr_result_select_tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, io_data_space = 1'b0;
    logic io_we = 1'b0, io_re = 1'b0, done_flag_clear = 1'b0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, sel, sel2, rv;
    logic conv_start, conv_complete, conversion_done_flag, conv_busy;
    logic [9:0] conv_code, code, prev;
    logic [1:0] reference_select;
    logic [4:0] channel_gain_select;
    logic external_reference_pin, analog_supply_reference;
    logic internal_ref_enable, result_is_differential;
    logic [15:0] fx;
    // Corner codes; zero is the offset reading with one channel on both
    logic [9:0] corn [5] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h270};
    int n_fail = 0, cmp_count = 0, seed = 30;
    always #5 clk_sys = ~clk_sys;
    acr_result_select u_acr_result_select (.*);
    acr_analog_model u_acr_analog_model (.*);
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One strobe cycle, then one idle cycle so two calls never collide
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input bit w);
        io_addr = a;
        io_data_space = (a >= 8'h20);
        io_wdata = d;
        io_we = w;
        io_re = !w;
        @(negedge clk_sys);
        rv = io_rdata;
        io_we = 1'b0;
        io_re = 1'b0;
        @(negedge clk_sys);
    endtask : acc
    function automatic logic is_diff(input logic [4:0] ch);
        return (ch >= 5'h08) && (ch <= 5'h1d);
    endfunction : is_diff
    function automatic logic [15:0] fmt(input logic [9:0] c, input logic la);
        return la ? {c, 6'h00} : {6'h00, c};
    endfunction : fmt
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        acc(8'h07, 8'h00, 0);
        chk(rv, 8'h00);
        acc(8'h10, 8'hff, 1);
        acc(8'h10, 8'h00, 0);
        chk(rv, 8'h00);
        for (int r = 0; r < 4; r++) begin
            acc(8'h27, 8'(r << 6) | 8'h0d, 1);
            acc(8'h07, 8'h00, 0);
            chk(rv, 8'(r << 6) | 8'h0d);
            chk(external_reference_pin, r == 0);
            chk(analog_supply_reference, r == 1);
            chk(internal_ref_enable, r == 3);
        end
        prev = 10'h000;
        for (int i = 0; i < 12; i++) begin
            code = (i < 5) ? corn[i] : 10'($random(seed));
            sel = 8'($random(seed));
            sel2 = (i == 4) ? 8'hed : 8'($random(seed));
            acc(8'h07, sel, 1);
            u_acr_analog_model.begin_conv();
            chk(conv_busy, 1'b1);
            acc(8'h27, sel2, 1);
            chk(reference_select, sel[7:6]);
            chk(channel_gain_select, sel[4:0]);
            fx = fmt(prev, sel2[5]);
            acc(8'h05, 8'h00, 0);
            chk(rv, fx[15:8]);
            u_acr_analog_model.end_conv(code);
            chk(conversion_done_flag, 1'b1);
            chk(conv_busy, 1'b0);
            chk(reference_select, sel2[7:6]);
            chk(channel_gain_select, sel2[4:0]);
            chk(result_is_differential, is_diff(sel2[4:0]));
            fx = fmt(code, sel2[5]);
            acc(8'h05, 8'h00, 0);
            chk(rv, fx[15:8]);
            acc(8'h24, 8'h00, 0);
            chk(rv, fx[7:0]);
            acc(8'h07, sel2 ^ 8'h20, 1);
            fx = fmt(code, ~sel2[5]);
            acc(8'h25, 8'h00, 0);
            chk(rv, fx[15:8]);
            done_flag_clear = 1'b1;
            acc(8'h04, 8'h00, 0);
            done_flag_clear = 1'b0;
            chk(rv, fx[7:0]);
            chk(conversion_done_flag, 1'b0);
            prev = code;
        end
        // Reset in mid-conversion returns outputs and registers to idle
        acc(8'h07, 8'hed, 1);
        u_acr_analog_model.begin_conv();
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk(conv_busy, 1'b0);
        chk({reference_select, channel_gain_select}, 7'h00);
        acc(8'h07, 8'h00, 0);
        chk(rv, 8'h00);
        acc(8'h05, 8'h00, 0);
        chk(rv, 8'h00);
        test_done();
    end
endmodule : acr_result_select_tb_top
`default_nettype wire
